//--- hw/ext_irq_pkg.sv
// constants for the external interrupt unit: register indices, field
// positions, sense encodings, vector numbers and reset values.
// assumes a 32-bit avalon-mm bus with one register per aligned word.
package ext_irq_pkg;

   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_TIMER_MASK = 6'h39; // timer_irq_enable_mask
   localparam logic [5:0] IDX_FLAG = 6'h3A;       // external_irq_flags
   localparam logic [5:0] IDX_GMASK = 6'h3B;      // ext_irq_mask_reg
   localparam logic [5:0] IDX_SENSE = 6'h35;      // sense select bits
   localparam logic [5:0] IDX_STATUS = 6'h3C;     // sticky event status
   localparam logic [5:0] IDX_SMASK = 6'h3D;      // status interrupt mask

   // field positions
   localparam int BIT_FLAG_B = 7;  // ext_irq_b_flag, also line b mask bit
   localparam int BIT_FLAG_A = 6;  // ext_irq_a_flag, also line a mask bit
   localparam int BIT_T2C_EN = 7;  // t2_compare_irq_en
   localparam int BIT_T2O_EN = 6;  // t2_overflow_irq_en
   localparam int SENSE_B_POS = 2; // line_b_sense_hi/lo
   localparam int SENSE_A_POS = 0; // line_a_sense_hi/lo

   // bit 1 of the timer mask is read-only zero
   localparam logic [7:0] TMASK_WR_MASK = 8'hFD;

   // reset values
   localparam logic [7:0] RST_REG8 = 8'h00;
   localparam logic [3:0] RST_SENSE = 4'h0;
   localparam logic [1:0] RST_PAIR = 2'h0;
   localparam logic LINE_IDLE = 1'b1;

   // sense select encoding
   typedef enum logic [1:0]
   {
      SENSE_LOW = 2'h0,
      SENSE_RSVD = 2'h1,
      SENSE_FALL = 2'h2,
      SENSE_RISE = 2'h3
   } sense_t;

   // vector numbers presented to the core
   localparam logic [2:0] VEC_NONE = 3'h0;
   localparam logic [2:0] VEC_A = 3'h1;
   localparam logic [2:0] VEC_B = 3'h2;
   localparam logic [2:0] VEC_T2C = 3'h3;
   localparam logic [2:0] VEC_T2O = 3'h4;

endpackage : ext_irq_pkg

//--- hw/line_sync.sv
// three-stage synchroniser and edge finder for one external request pin.
// assumes the pin is asynchronous to sys_clk.
`timescale 1ns/1ps

module line_sync
   import ext_irq_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic line_in,
   output logic level,
   output logic rise,
   output logic fall
);

   // all state of the synchroniser
   typedef struct packed
   {
      logic s1;   // first stage, read only by s2
      logic s2;
      logic s3;
      logic filt; // accepted pin level
   } sync_t;

   sync_t q;
   sync_t d;
   logic agree; // second and third stage match

   assign agree = (q.s2 == q.s3);
   assign level = q.filt;
   // new sample against previous accepted level
   assign rise = agree & q.s3 & ~q.filt;
   assign fall = agree & ~q.s3 & q.filt;

   // next state
   always_comb
   begin
      d = q;
      d.s1 = line_in;
      d.s2 = q.s1;
      d.s3 = q.s2;
      // a change counts only once two stages agree
      if (agree)
      begin
         d.filt = q.s3;
      end
   end

   // state register
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         q <= '{s1: LINE_IDLE, s2: LINE_IDLE, s3: LINE_IDLE, filt: LINE_IDLE};
      end
      else
      begin
         q <= d;
      end
   end

   // an accepted edge is reflected in the level a cycle later
   edge_level_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (rise |=> level) and (fall |=> !level))
      else $error("accepted edge did not update level");

endmodule : line_sync

//--- hw/external_interrupt_unit.sv
// external interrupt unit: two sensed request pins, sticky flags, vectored
// requests to the core and the timer 2 interrupt enables.
// assumes an avalon-mm master on sys_clk and a core that pulses core_ack
// while it takes the vector presented on irq_vector.
`timescale 1ns/1ps

// Overview of operation
// - set line b flag on selected edge
// - flags held zero in low-level mode
// - line b vectors 2, line a vector 1
// - edge flag cleared when service taken
// - writing one clears a flag
// - low six flag bits read zero
// - timer 2 compare vectors 3 when enabled
// - timer 2 overflow vectors 4 when enabled
// - line b: 00 low, 10 fall, 11 rise
// - line a uses same sense encoding
// - pins sampled on clock before edge detect
// - low level requests while pin low
// - request needs global and own enable
module external_interrupt_unit
   import ext_irq_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic ext_irq_line_a,
   input wire logic ext_irq_line_b,
   input wire logic global_irq_en,
   input wire logic t2_compare_flag,
   input wire logic t2_overflow_flag,
   input wire logic core_ack,
   output logic irq_req,
   output logic [2:0] irq_vector,
   output logic irq_out
);

   // true when the byte address selects the given register index
   function automatic logic is_reg(input logic [7:0] addr, input logic [5:0] idx);
      return (addr[7:2] == idx) && (addr[1:0] == 2'h0);
   endfunction : is_reg

   // true when the sampled edge matches the selected sense mode
   function automatic logic edge_hit(input logic [1:0] sel, input logic r,
                                     input logic f);
      logic hit;
      hit = 1'b0;
      // reserved and low-level codes never raise an edge request
      if (sel == SENSE_FALL)
      begin
         hit = f;
      end
      else if (sel == SENSE_RISE)
      begin
         hit = r;
      end
      return hit;
   endfunction : edge_hit

   // all state of the unit
   typedef struct packed
   {
      logic ack;          // bus answer phase
      logic [7:0] rdata;  // captured read data
      logic [7:0] tmask;  // timer_irq_enable_mask
      logic [1:0] gmask;  // line enables {b, a}
      logic [3:0] sense;  // {b hi, b lo, a hi, a lo}
      logic [1:0] flag;   // {ext_irq_b_flag, ext_irq_a_flag}
      logic [1:0] sts;    // sticky edge events {b, a}
      logic [1:0] smask;  // status mask {b, a}
      logic req;          // request to core
      logic [2:0] vec;    // vector to core
   } state_t;

   state_t q;
   state_t d;

   // synchronised pins
   logic lvl_a;
   logic lvl_b;
   logic rise_a;
   logic rise_b;
   logic fall_a;
   logic fall_b;

   // decoded helpers
   logic [1:0] sel_a;      // line a sense code
   logic [1:0] sel_b;      // line b sense code
   logic hit_a;            // selected edge on line a
   logic hit_b;            // selected edge on line b
   logic low_a;            // line a in low-level mode
   logic low_b;            // line b in low-level mode
   logic wr_go;            // write takes effect this edge
   logic [1:0] flag_w1c;   // ones written to the flag register
   logic [1:0] sts_w1c;    // ones written to the status register
   logic ack_a;            // core takes vector 1
   logic ack_b;            // core takes vector 2
   logic [3:0] src;        // gated sources {t2o, t2c, b, a}
   logic [7:0] rd_mux;     // read value of the addressed register

   // one synchroniser per pin
   line_sync sync_a (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .line_in(ext_irq_line_a),
      .level(lvl_a),
      .rise(rise_a),
      .fall(fall_a)
   );

   line_sync sync_b (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .line_in(ext_irq_line_b),
      .level(lvl_b),
      .rise(rise_b),
      .fall(fall_b)
   );

   // sense decoding, same encoding on both lines
   assign sel_b = q.sense[SENSE_B_POS +: 2];
   assign sel_a = q.sense[SENSE_A_POS +: 2];
   assign hit_b = edge_hit(sel_b, rise_b, fall_b);
   assign hit_a = edge_hit(sel_a, rise_a, fall_a);
   assign low_b = (sel_b == SENSE_LOW);
   assign low_a = (sel_a == SENSE_LOW);

   // bus side strobes; the write lands on the edge waitrequest is low
   assign wr_go = write & q.ack;
   assign flag_w1c = (wr_go && is_reg(address, IDX_FLAG)) ?
                     writedata[BIT_FLAG_A +: 2] : RST_PAIR;
   assign sts_w1c = (wr_go && is_reg(address, IDX_STATUS)) ?
                    writedata[1:0] : RST_PAIR;

   // service entry clears only the flag whose vector was taken
   assign ack_a = core_ack & q.req & (q.vec == VEC_A);
   assign ack_b = core_ack & q.req & (q.vec == VEC_B);

   // gated sources; low-level mode follows the pin, not the flag
   assign src[0] = global_irq_en & q.gmask[0] & (low_a ? ~lvl_a : q.flag[0]);
   assign src[1] = global_irq_en & q.gmask[1] & (low_b ? ~lvl_b : q.flag[1]);
   assign src[2] = global_irq_en & q.tmask[BIT_T2C_EN] & t2_compare_flag;
   assign src[3] = global_irq_en & q.tmask[BIT_T2O_EN] & t2_overflow_flag;

   // read multiplexer; unmapped addresses read zero
   always_comb
   begin
      rd_mux = RST_REG8;
      if (is_reg(address, IDX_TIMER_MASK))
      begin
         rd_mux = q.tmask;
      end
      else if (is_reg(address, IDX_FLAG))
      begin
         rd_mux = {q.flag, 6'h00};
      end
      else if (is_reg(address, IDX_GMASK))
      begin
         rd_mux = {q.gmask, 6'h00};
      end
      else if (is_reg(address, IDX_SENSE))
      begin
         rd_mux = {4'h0, q.sense};
      end
      else if (is_reg(address, IDX_STATUS))
      begin
         rd_mux = {6'h00, q.sts};
      end
      else if (is_reg(address, IDX_SMASK))
      begin
         rd_mux = {6'h00, q.smask};
      end
   end

   // next state
   always_comb
   begin
      d = q;
      // one wait cycle per access, then answer
      d.ack = (read | write) & ~q.ack;
      if (read && !q.ack)
      begin
         d.rdata = rd_mux;
      end
      // plain register writes; unmapped writes are dropped
      if (wr_go)
      begin
         if (is_reg(address, IDX_TIMER_MASK))
         begin
            d.tmask = writedata[7:0] & TMASK_WR_MASK;
         end
         else if (is_reg(address, IDX_GMASK))
         begin
            d.gmask = writedata[BIT_FLAG_A +: 2];
         end
         else if (is_reg(address, IDX_SENSE))
         begin
            d.sense = writedata[3:0];
         end
         else if (is_reg(address, IDX_SMASK))
         begin
            d.smask = writedata[1:0];
         end
      end
      // line b flag: new edge wins over any clear in the same cycle
      if (low_b)
      begin
         d.flag[1] = 1'b0;
      end
      else
      begin
         d.flag[1] = (q.flag[1] & ~(flag_w1c[1] | ack_b)) | hit_b;
      end
      // line a flag, same treatment
      if (low_a)
      begin
         d.flag[0] = 1'b0;
      end
      else
      begin
         d.flag[0] = (q.flag[0] & ~(flag_w1c[0] | ack_a)) | hit_a;
      end
      // sticky status of edge events, set over clear
      d.sts = (q.sts & ~sts_w1c) | {hit_b, hit_a};
      // fixed priority, lowest vector first
      d.req = |src;
      if (src[0])
      begin
         d.vec = VEC_A;
      end
      else if (src[1])
      begin
         d.vec = VEC_B;
      end
      else if (src[2])
      begin
         d.vec = VEC_T2C;
      end
      else if (src[3])
      begin
         d.vec = VEC_T2O;
      end
      else
      begin
         d.vec = VEC_NONE;
      end
   end

   // state register
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         q <= '{ack: 1'b0, rdata: RST_REG8, tmask: RST_REG8, gmask: RST_PAIR,
                sense: RST_SENSE, flag: RST_PAIR, sts: RST_PAIR, smask: RST_PAIR,
                req: 1'b0, vec: VEC_NONE};
      end
      else
      begin
         q <= d;
      end
   end

   // outputs
   assign waitrequest = (read | write) & ~q.ack;
   assign readdata = {24'h000000, q.rdata};
   assign irq_req = q.req;
   assign irq_vector = q.vec;
   // level interrupt while any unmasked sticky bit is set
   assign irq_out = |(q.sts & q.smask);

   // checks

   flag_b_set_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      hit_b |=> q.flag[1])
      else $error("line b edge did not set its flag");

   level_zero_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (low_a || low_b) |=> ((!q.flag[0] || !$past(low_a)) && (!q.flag[1] || !$past(low_b))))
      else $error("flag set while line in low-level mode");

   vector_b_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (src[1] && !src[0]) |=> (irq_req && irq_vector == VEC_B))
      else $error("line b request did not present vector 2");

   ack_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (ack_a && !hit_a) |=> !q.flag[0])
      else $error("service entry did not clear line a flag");

   w1c_flag_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (wr_go && is_reg(address, IDX_FLAG) && writedata[BIT_FLAG_B] && !hit_b)
      |=> !q.flag[1])
      else $error("writing one did not clear line b flag");

   rsvd_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (read && q.ack && is_reg(address, IDX_FLAG)) |-> (readdata[5:0] == 6'h00))
      else $error("reserved flag bits read nonzero");

   t2_compare_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (global_irq_en && q.tmask[BIT_T2C_EN] && t2_compare_flag && src[1:0] == 2'h0)
      |=> (irq_req && irq_vector == VEC_T2C))
      else $error("timer 2 compare did not present vector 3");

   t2_overflow_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (src == 4'h8) |=> (irq_req && irq_vector == VEC_T2O))
      else $error("timer 2 overflow did not present vector 4");

   level_req_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (global_irq_en && q.gmask[0] && low_a && !lvl_a) [*2] |-> irq_req)
      else $error("held low level not requesting");

   gate_off_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      !global_irq_en |=> !irq_req)
      else $error("request raised with global enable low");

endmodule : external_interrupt_unit

//--- testbench/ext_irq_partner.sv
// far-side model: two request pins, timer 2 flags and the core taking vectors.
// assumes one bench process calls its tasks; all changes land after a rising edge.
`timescale 1ns/1ps

module ext_irq_partner
(
   input wire logic sys_clk,
   input wire logic irq_req,
   output logic line_a,
   output logic line_b,
   output logic gie,
   output logic t2c,
   output logic t2o,
   output logic core_ack
);
   // pins idle high across reset so no false edge is seen
   initial
   begin
      {line_a, line_b, gie, t2c, t2o, core_ack} = 6'b110000;
   end

   // low pulse of n cycles; never shorter than two clocks
   task automatic pulse(input bit b, input int n);
      @(posedge sys_clk);
      if (b)
         line_b <= 1'b0;
      else
         line_a <= 1'b0;
      repeat (n) @(posedge sys_clk);
      line_a <= 1'b1;
      line_b <= 1'b1;
   endtask : pulse

   // static pin levels; a low level stays until released
   task automatic lines(input logic a, input logic b);
      @(posedge sys_clk);
      line_a <= a;
      line_b <= b;
   endtask : lines

   // global enable and timer flag levels
   task automatic set_core(input logic g, input logic c, input logic o);
      @(posedge sys_clk);
      gie <= g;
      t2c <= c;
      t2o <= o;
   endtask : set_core

   // core waits for a request, then acks for one cycle
   task automatic take(output bit seen);
      int n;
      n = 0;
      seen = 1'b0;
      while (!seen && n < 20)
      begin
         @(negedge sys_clk);
         seen = (irq_req === 1'b1);
         n++;
      end
      if (seen)
      begin
         @(posedge sys_clk);
         core_ack <= 1'b1;
         @(posedge sys_clk);
         core_ack <= 1'b0;
      end
   endtask : take
endmodule : ext_irq_partner

//--- testbench/tb_external_interrupt_unit.sv
// self-checking bench for the external interrupt unit; reads and vectors are
// noted in queues and compared by a watcher process.
// assumes ext_irq_partner plays pins, timer and core.
`timescale 1ns/1ps

module tb_external_interrupt_unit import ext_irq_pkg::*;;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] address = 8'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic waitrequest, irq_req, irq_out, core_ack, gie, t2c, t2o, line_a, line_b;
   logic [2:0] irq_vector;
   logic [7:0] rq[$]; // expected read bytes
   logic [2:0] vq[$]; // expected vectors
   int err_total = 0;
   int comparisons = 0;
   int seed = 36722;
   logic [31:0] r;
   logic [7:0] e;
   bit seen;

   always #12.5 sys_clk = ~sys_clk;

   external_interrupt_unit u_external_interrupt_unit (.sys_clk(sys_clk), .resetn(resetn),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .ext_irq_line_a(line_a),
      .ext_irq_line_b(line_b), .global_irq_en(gie), .t2_compare_flag(t2c),
      .t2_overflow_flag(t2o), .core_ack(core_ack), .irq_req(irq_req),
      .irq_vector(irq_vector), .irq_out(irq_out));

   ext_irq_partner u_ext_irq_partner (.sys_clk(sys_clk), .irq_req(irq_req),
      .line_a(line_a), .line_b(line_b), .gie(gie), .t2c(t2c), .t2o(t2o),
      .core_ack(core_ack));

   function automatic void cmp(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD at %0t got %h expected %h", $time, got, exp);
      end
   endfunction : cmp

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finish_test

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : cyc

   // one avalon access; upper write bits random since only the low byte counts
   task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] d);
      int n;
      logic [31:0] junk;
      n = 0;
      junk = $random(seed);
      @(posedge sys_clk);
      address <= {idx, 2'b00};
      writedata <= {junk[31:8], d};
      read <= ~wr;
      write <= wr;
      // no wait limit here; a hung slave is left to the watchdog
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (waitrequest !== 1'b0);
      // released only after the edge that saw waitrequest low
      read <= 1'b0;
      write <= 1'b0;
      cmp(n, 32'h2); // one wait state, then the answer
   endtask : bus

   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask : wr

   task automatic rd(input logic [5:0] idx, input logic [7:0] d);
      rq.push_back(d);
      bus(1'b0, idx, 8'h00);
   endtask : rd

   // note the vector, let the core take it, let flags settle
   task automatic want_vec(input logic [2:0] v);
      vq.push_back(v);
      u_ext_irq_partner.take(seen);
      if (!seen)
         cmp(irq_req, 1'b1);
      cyc(3);
   endtask : want_vec

   // watcher: looks at the very edge where read data and the vector are taken
   always @(posedge sys_clk)
   begin
      if (read && waitrequest === 1'b0)
         cmp(readdata, rq.size() ? {24'h0, rq.pop_front()} : 32'hFFFFFFFF);
      if (core_ack && irq_req === 1'b1)
         cmp(irq_vector, vq.size() ? vq.pop_front() : 3'h7);
   end

   // watchdog well beyond the few hundred cycles the run needs
   initial
   begin
      cyc(8000);
      err_total++;
      finish_test();
   end

   initial
   begin
      cyc(5);
      resetn <= 1'b1;
      rd(IDX_TIMER_MASK, 8'h00);
      rd(IDX_FLAG, 8'h00);
      wr(6'h00, 8'hFF);
      rd(6'h00, 8'h00);
      r = $random(seed);
      wr(IDX_TIMER_MASK, r[7:0]);
      rd(IDX_TIMER_MASK, r[7:0] & TMASK_WR_MASK);
      wr(IDX_TIMER_MASK, 8'h00);
      wr(IDX_FLAG, 8'h3F);
      rd(IDX_FLAG, 8'h00);
      // every sense code on both lines, requests masked
      for (int i = 0; i < 8; i++)
      begin
         wr(IDX_SENSE, i[0] ? {4'h0, i[2:1], 2'h0} : {6'h0, i[2:1]});
         r = $random(seed);
         u_ext_irq_partner.pulse(i[0], 2 + r[1:0]);
         cyc(8);
         e = i[2] ? (i[0] ? 8'h80 : 8'h40) : 8'h00;
         @(negedge sys_clk);
         cmp({irq_out, irq_req}, 2'b00);
         rd(IDX_FLAG, e);
         wr(IDX_FLAG, 8'h00);
         rd(IDX_FLAG, e);
         rd(IDX_STATUS, {6'h0, e[7], e[6]});
         wr(IDX_STATUS, 8'h03);
         wr(IDX_FLAG, 8'hC0);
         rd(IDX_FLAG, 8'h00);
      end
      // status interrupt masked, then raised, cleared
      wr(IDX_SENSE, 8'h0A);
      rd(IDX_SENSE, 8'h0A);
      u_ext_irq_partner.pulse(1'b0, 3);
      cyc(8);
      @(negedge sys_clk);
      cmp(irq_out, 1'b0);
      wr(IDX_SMASK, 8'h01);
      @(negedge sys_clk);
      cmp(irq_out, 1'b1);
      wr(IDX_STATUS, 8'h01);
      @(negedge sys_clk);
      cmp(irq_out, 1'b0);
      // own masks set but global enable off
      wr(IDX_GMASK, 8'hC0);
      rd(IDX_GMASK, 8'hC0);
      cyc(3);
      @(negedge sys_clk);
      cmp(irq_req, 1'b0);
      u_ext_irq_partner.set_core(1'b1, 1'b0, 1'b0);
      u_ext_irq_partner.pulse(1'b1, 3);
      cyc(8);
      want_vec(VEC_A);
      want_vec(VEC_B);
      rd(IDX_FLAG, 8'h00);
      // line b low level keeps requesting
      wr(IDX_SENSE, 8'h02);
      u_ext_irq_partner.lines(1'b1, 1'b0);
      cyc(6);
      want_vec(VEC_B);
      want_vec(VEC_B);
      rd(IDX_FLAG, 8'h00);
      // line a low level as well; it outranks line b
      wr(IDX_SENSE, 8'h00);
      u_ext_irq_partner.lines(1'b0, 1'b0);
      cyc(6);
      want_vec(VEC_A);
      rd(IDX_FLAG, 8'h00);
      u_ext_irq_partner.lines(1'b1, 1'b1);
      cyc(6);
      @(negedge sys_clk);
      cmp(irq_req, 1'b0);
      // timer sources
      wr(IDX_TIMER_MASK, 8'h80);
      u_ext_irq_partner.set_core(1'b1, 1'b0, 1'b1);
      cyc(3);
      @(negedge sys_clk);
      cmp(irq_req, 1'b0);
      u_ext_irq_partner.set_core(1'b1, 1'b1, 1'b1);
      cyc(3);
      want_vec(VEC_T2C);
      want_vec(VEC_T2C);
      u_ext_irq_partner.set_core(1'b1, 1'b0, 1'b1);
      wr(IDX_TIMER_MASK, 8'hC0);
      cyc(3);
      want_vec(VEC_T2O);
      u_ext_irq_partner.set_core(1'b0, 1'b1, 1'b1);
      cyc(3);
      @(negedge sys_clk);
      cmp(irq_req, 1'b0);
      finish_test();
   end
endmodule : tb_external_interrupt_unit
